// ---- hdl/counter_defines.vh ----
// constants shared by the up/down counter and its step logic
// assumes: included by bare name from every design file that needs it
`ifndef COUNTER_DEFINES_VH
`define COUNTER_DEFINES_VH

// ==========================================================
// register port widths
`define REG_ADDR_W        8
`define REG_DATA_W        8

// ==========================================================
// register offsets
`define ADDR_CTRL         8'h00
`define ADDR_STEP         8'h04
`define ADDR_STATE        8'h08
`define ADDR_IRQ_STATUS   8'h0c
`define ADDR_IRQ_MASK     8'h10

// ==========================================================
// control register fields and reset value
`define CTRL_DECIMAL      0
`define CTRL_PIN_EN       1
`define CTRL_RESET        8'h02

// step register field
`define STEP_GO           0

// state register fields
`define STATE_TC_N        4
`define STATE_ILLEGAL     5

// ==========================================================
// interrupt status and mask fields
`define IRQ_TC            0
`define IRQ_LOAD          1
`define IRQ_ILLEGAL       2
`define IRQ_W             3
`define IRQ_MASK_RESET    3'h0

// ==========================================================
// count values
`define COUNT_ZERO        4'h0
`define DEC_MAX           4'h9
`define BIN_MAX           4'hf
`define COUNT_RESET       4'h0

// ==========================================================
// pin synchroniser width and reset value (all inputs idle high)
`define SYNC_W            9
`define SYNC_RESET        9'h1ff

`endif

// ---- hdl/count_step.v ----
// next count value for one step of the four-bit up/down counter
// assumes: purely combinational, used by the counter top level
`timescale 1ns/100ps
`include "counter_defines.vh"

module count_step (
  // present state and mode
  input  wire [3:0] state,
  input  wire       decimal,
  input  wire       up,
  // value after one count
  output reg  [3:0] next_state
);

  wire [3:0] plus_one;
  wire [3:0] minus_one;

  // four-bit arithmetic wraps by itself in binary mode
  assign plus_one  = state + 4'h1;
  assign minus_one = state - 4'h1;

  // ==========================================================
  // step decode
  always @* begin
    next_state = state;
    if (decimal) begin
      if (up) begin
        if (state == `DEC_MAX) begin
          next_state = `COUNT_ZERO;
        // odd unused state exits to zero
        end else if (state > `DEC_MAX) begin
          next_state = state[0] ? `COUNT_ZERO : plus_one;
        end else begin
          next_state = plus_one;
        end
      end else begin
        if (state == `COUNT_ZERO) begin
          next_state = `DEC_MAX;
        // even unused state exits to nine
        end else if (state > `DEC_MAX) begin
          next_state = state[0] ? minus_one : `DEC_MAX;
        end else begin
          next_state = minus_one;
        end
      end
    end else begin
      next_state = up ? plus_one : minus_one;
    end
  end

endmodule // count_step

// ---- hdl/presettable_updown_counter.v ----
// four-stage presettable up/down counter, decimal or binary
// assumes: one 50 MHz clock, synchronous active-low reset, all
// counter pins asynchronous to clk, register master never waits
`timescale 1ns/100ps
`include "counter_defines.vh"

module presettable_updown_counter (
  // clock and reset
  input  wire                   clk,
  input  wire                   resetn,
  // counter pins
  input  wire                   count_clock,
  input  wire                   parallel_load_n,
  input  wire                   count_enable_par_n,
  input  wire                   count_enable_trickle_n,
  input  wire                   up_down,
  input  wire [3:0]             preset_inputs,
  output reg  [3:0]             count_outputs,
  output reg                    terminal_count_n,
  // register port
  input  wire [`REG_ADDR_W-1:0] reg_addr,
  input  wire [`REG_DATA_W-1:0] reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [`REG_DATA_W-1:0] reg_rdata,
  // interrupt
  output reg                    irq
);

  // ==========================================================
  // decode helpers

  // terminal count decode from state, mode, direction, trickle
  function tc_active;
    input [3:0] st;
    input       dec;
    input       up;
    input       trickle_n;
    begin
      if (trickle_n) begin
        tc_active = 1'b0;
      end else if (up) begin
        // decimal: 9, 11, 13, 15 all have bits 0 and 3 set
        tc_active = dec ? (st[0] & st[3]) : (st == `BIN_MAX);
      end else begin
        tc_active = (st == `COUNT_ZERO);
      end
    end
  endfunction

  // state outside zero to nine while in decimal mode
  function illegal_state;
    input [3:0] st;
    input       dec;
    begin
      illegal_state = dec & (st > `DEC_MAX);
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  wire [`SYNC_W-1:0] pin_raw;
  // reset image of the synchronisers, one bit per pin
  wire [`SYNC_W-1:0] sync_init = `SYNC_RESET;
  reg  [`SYNC_W-1:0] sync_meta;
  reg  [`SYNC_W-1:0] sync_pin;
  reg                clock_prev;

  assign pin_raw = {count_clock, parallel_load_n, count_enable_par_n,
                    count_enable_trickle_n, up_down, preset_inputs};

  // two flops per pin; only the second stage is used downstream
  genvar gi;
  generate
    for (gi = 0; gi < `SYNC_W; gi = gi + 1) begin : g_sync
      always @(posedge clk) begin
        if (!resetn) begin
          sync_meta[gi] <= sync_init[gi];
          sync_pin[gi]  <= sync_init[gi];
        end else begin
          sync_meta[gi] <= pin_raw[gi];
          sync_pin[gi]  <= sync_meta[gi];
        end
      end
    end
  endgenerate

  // all pins share the same delay, so data stays aligned with the edge
  wire       s_clock     = sync_pin[8];
  wire       s_load_n    = sync_pin[7];
  wire       s_cep_n     = sync_pin[6];
  wire       s_cet_n     = sync_pin[5];
  wire       s_up        = sync_pin[4];
  wire [3:0] s_preset    = sync_pin[3:0];

  // previous synchronised clock level, for rising edge detect
  always @(posedge clk) begin
    if (!resetn) begin
      clock_prev <= 1'b1;
    end else begin
      clock_prev <= s_clock;
    end
  end

  // ==========================================================
  // registers
  reg  [`REG_DATA_W-1:0] ctrl;
  reg  [`IRQ_W-1:0]      irq_status;
  reg  [`IRQ_W-1:0]      irq_mask;
  reg                    sw_step;
  reg  [`IRQ_W-1:0]      next_irq_status;
  reg  [`IRQ_W-1:0]      next_irq_mask;

  wire decimal_mode = ctrl[`CTRL_DECIMAL];
  wire pin_enable   = ctrl[`CTRL_PIN_EN];

  // address decode of writes
  wire wr_ctrl   = reg_wr & (reg_addr == `ADDR_CTRL);
  wire wr_step   = reg_wr & (reg_addr == `ADDR_STEP);
  wire wr_status = reg_wr & (reg_addr == `ADDR_IRQ_STATUS);
  wire wr_mask   = reg_wr & (reg_addr == `ADDR_IRQ_MASK);

  // ==========================================================
  // step enable: a pin edge or a software step, one cycle each
  // act only on the sampled count edge
  wire pin_edge = pin_enable & s_clock & ~clock_prev;
  wire step     = pin_edge | sw_step;

  // software step is registered so it acts one cycle after the write
  always @(posedge clk) begin
    if (!resetn) begin
      sw_step <= 1'b0;
    end else begin
      sw_step <= wr_step & reg_wdata[`STEP_GO];
    end
  end

  // ==========================================================
  // counter core
  wire [3:0] stepped;
  reg  [3:0] next_count;
  reg        load_done;

  count_step u_step (
    .state      (count_outputs),
    .decimal    (decimal_mode),
    .up         (s_up),
    .next_state (stepped)
  );

  // mode select: load, count, hold
  always @* begin
    next_count = count_outputs;
    load_done  = 1'b0;
    if (step) begin
      if (!s_load_n) begin
        next_count = s_preset;
        load_done  = 1'b1;
      end else if (!s_cep_n && !s_cet_n) begin
        next_count = stepped;
      end
    end
  end

  // ==========================================================
  // terminal count, registered so the output is glitch free
  // (taken from next_count, so it changes in the same cycle as the state it describes)
  wire next_tc_n;

  // end value with trickle low; no parallel enable term
  // unused odd decimal states also decode when counting up
  assign next_tc_n = ~tc_active(next_count, decimal_mode, s_up, s_cet_n);

  always @(posedge clk) begin
    if (!resetn) begin
      count_outputs    <= `COUNT_RESET;
      terminal_count_n <= 1'b1;
    end else begin
      count_outputs    <= next_count;
      terminal_count_n <= next_tc_n;
    end
  end

  // ==========================================================
  // events for the interrupt status
  wire [`IRQ_W-1:0] events;
  wire              now_illegal  = illegal_state(count_outputs, decimal_mode);
  wire              next_illegal = illegal_state(next_count, decimal_mode);

  assign events[`IRQ_TC]      = terminal_count_n & ~next_tc_n;
  assign events[`IRQ_LOAD]    = load_done;
  assign events[`IRQ_ILLEGAL] = next_illegal & ~now_illegal;

  // write one to clear; a new event in the same cycle wins
  always @* begin
    next_irq_status = irq_status;
    if (wr_status) begin
      next_irq_status = irq_status & ~reg_wdata[`IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | events;
    next_irq_mask   = wr_mask ? reg_wdata[`IRQ_W-1:0] : irq_mask;
  end

  // control, status, mask and the level interrupt
  always @(posedge clk) begin
    if (!resetn) begin
      ctrl       <= `CTRL_RESET;
      irq_status <= {`IRQ_W{1'b0}};
      irq_mask   <= `IRQ_MASK_RESET;
      irq        <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata & 8'h03;
      end
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      irq        <= |(next_irq_status & next_irq_mask);
    end
  end

  // ==========================================================
  // read port: data only in the cycle after the strobe
  reg [`REG_DATA_W-1:0] read_mux;

  always @* begin
    read_mux = 8'h00;
    if (reg_addr == `ADDR_CTRL) begin
      read_mux = ctrl;
    end else if (reg_addr == `ADDR_STATE) begin
      read_mux[3:0]            = count_outputs;
      read_mux[`STATE_TC_N]    = terminal_count_n;
      read_mux[`STATE_ILLEGAL] = now_illegal;
    end else if (reg_addr == `ADDR_IRQ_STATUS) begin
      read_mux[`IRQ_W-1:0] = irq_status;
    end else if (reg_addr == `ADDR_IRQ_MASK) begin
      read_mux[`IRQ_W-1:0] = irq_mask;
    end
  end

  // unmapped and step addresses read zero
  always @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? read_mux : 8'h00;
    end
  end

endmodule // presettable_updown_counter

// ---- sim/counter_checker_properties.sv ----
// assertion checker for the up/down counter top level
// assumes: bound to every counter instance, sees only its ports
`timescale 1ns/100ps
`include "counter_defines.vh"

module counter_checker (
  // clock and reset
  input wire       clk,
  input wire       resetn,
  // counter pins
  input wire       count_clock,
  input wire       parallel_load_n,
  input wire       count_enable_par_n,
  input wire       count_enable_trickle_n,
  input wire       up_down,
  input wire [3:0] preset_inputs,
  input wire [3:0] count_outputs,
  input wire       terminal_count_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // interrupt
  input wire       irq
);
  // ========================================
  // one domain, so one clocking and disable
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_RESET: assert property (
    !$past(resetn) |-> count_outputs == 4'h0 && terminal_count_n && !irq)
    else $error("outputs not idle after reset");
  AST_TC_STATE: assert property (
    !terminal_count_n |-> count_outputs inside {4'h0, 4'h9, 4'hb, 4'hd, 4'hf})
    else $error("terminal count low in a wrong state");
  AST_TC_TRICKLE: assert property (
    !terminal_count_n |-> !$past(count_enable_trickle_n, 2) ||
      !$past(count_enable_trickle_n, 3) || !$past(count_enable_trickle_n, 4))
    else $error("terminal count low with trickle enable high");
  AST_TC_ZERO_DOWN: assert property (
    !terminal_count_n && count_outputs == 4'h0 |->
      !$past(up_down, 2) || !$past(up_down, 3) || !$past(up_down, 4))
    else $error("terminal count low at zero counting up");
  // parallel enable alone must never move terminal count
  AST_TC_CEP: assert property (
    ($stable(count_outputs) && $stable(up_down) && !reg_wr &&
      $stable(count_enable_trickle_n))[*5] |-> $stable(terminal_count_n))
    else $error("terminal count moved with state and trickle quiet");
  AST_HOLD: assert property (
    (!count_clock && !reg_wr)[*5] |-> $stable(count_outputs))
    else $error("state moved without a count edge");
  AST_LOAD: assert property (
    $changed(count_outputs) && !$past(parallel_load_n, 2) &&
      !$past(parallel_load_n, 3) && !$past(parallel_load_n, 4) |->
      count_outputs == $past(preset_inputs, 3))
    else $error("load did not copy the preset inputs");
  AST_STEP: assert property (
    $changed(count_outputs) && $past(parallel_load_n, 2) &&
      $past(parallel_load_n, 3) && $past(parallel_load_n, 4) |->
      (4'(count_outputs - $past(count_outputs)) inside {4'h1, 4'hf}) ||
      (count_outputs inside {4'h0, 4'h9}))
    else $error("count step was not one up or down");

  // main scenarios seen
  cover property (!terminal_count_n);
  cover property (irq);
  cover property ($changed(count_outputs) && !$past(parallel_load_n, 3));
endmodule // counter_checker

bind presettable_updown_counter counter_checker u_chk (
  .clk                    (clk),
  .resetn                 (resetn),
  .count_clock            (count_clock),
  .parallel_load_n        (parallel_load_n),
  .count_enable_par_n     (count_enable_par_n),
  .count_enable_trickle_n (count_enable_trickle_n),
  .up_down                (up_down),
  .preset_inputs          (preset_inputs),
  .count_outputs          (count_outputs),
  .terminal_count_n       (terminal_count_n),
  .reg_addr               (reg_addr),
  .reg_wdata              (reg_wdata),
  .reg_wr                 (reg_wr),
  .reg_rd                 (reg_rd),
  .reg_rdata              (reg_rdata),
  .irq                    (irq)
);

// ---- sim/ctrl_model.sv ----
// control logic model: sets the counter pins, then one count clock pulse
// assumes: go is a one-cycle request, done a one-cycle answer
`timescale 1ns/100ps

module ctrl_model (
  // clock and request
  input  wire       clk,
  input  wire       go,
  input  wire [7:0] cmd,
  input  wire [3:0] gap,
  // counter pins: load_n, cep_n, cet_n, up, data
  output reg        count_clock,
  output reg  [7:0] pins,
  output reg        done
);
  initial begin
    count_clock = 1'b0;
    pins = 8'hff;
    done = 1'b0;
  end

  // ========================================
  // pulses come from clk only, never from terminal count
  // pins held long before and after the rise; gap makes it slow
  always begin
    @(posedge clk);
    if (go) begin
      pins <= cmd;
      repeat (3 + gap) @(posedge clk);
      count_clock <= 1'b1;
      repeat (3) @(posedge clk);
      count_clock <= 1'b0;
      repeat (6) @(posedge clk);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
    end
  end
endmodule // ctrl_model

// ---- sim/tb_presettable_updown_counter.sv ----
// self-checking bench for the up/down counter
// assumes: partner model drives the pins, bench owns the register port
`timescale 1ns/100ps
`include "counter_defines.vh"

module tb_presettable_updown_counter;
  reg        clk;
  reg        resetn;
  reg  [7:0] reg_addr;
  reg  [7:0] reg_wdata;
  reg        reg_wr;
  reg        reg_rd;
  reg        go;
  reg  [7:0] cmd;
  reg  [3:0] gap;
  wire [7:0] pins;
  wire [3:0] count_outputs;
  wire [7:0] reg_rdata;
  wire       count_clock;
  wire       terminal_count_n;
  wire       irq;
  wire       done;
  integer    err_total;
  integer    samples_checked;
  integer    cyc;

  ctrl_model u_ctrl (.clk(clk), .go(go), .cmd(cmd), .gap(gap),
    .count_clock(count_clock), .pins(pins), .done(done));

  presettable_updown_counter DUT (.clk(clk), .resetn(resetn),
    .count_clock(count_clock), .parallel_load_n(pins[7]),
    .count_enable_par_n(pins[6]), .count_enable_trickle_n(pins[5]),
    .up_down(pins[4]), .preset_inputs(pins[3:0]),
    .count_outputs(count_outputs), .terminal_count_n(terminal_count_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  // ========================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // the whole run needs under four hundred cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      err_total = err_total + 1;
      final_report;
    end
  end

  task final_report;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task chk(input [7:0] seen, input [7:0] exp, input [63:0] what);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("BAD %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  // ========================================
  // register port: one-cycle strobes, data one cycle after a read
  task wr(input [7:0] a, input [7:0] v);
    begin
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
    end
  endtask

  task rchk(input [7:0] a, input [7:0] e);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      // read data stand in the cycle after the strobe; take them at its end
      @(posedge clk);
      chk(reg_rdata, e, "reg");
      // the counter pins must agree with the state register
      if (a == `ADDR_STATE)
        chk({3'h0, terminal_count_n, count_outputs}, e & 8'h1f, "pins");
    end
  endtask

  // one pin operation: cmd is load_n, cep_n, cet_n, up, data
  task op(input [7:0] c, input [3:0] g);
    integer n;
    begin
      cmd <= c;
      gap <= g;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 40) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 40)
        err_total = err_total + 1;
    end
  endtask

  // ========================================
  // main sequence; state reads {illegal, tc_n, count}
  initial begin
    err_total = 0;
    samples_checked = 0;
    cyc = 0;
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    go = 1'b0;
    cmd = 8'hff;
    gap = 4'h0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rchk(`ADDR_STATE, 8'h10);
    rchk(`ADDR_CTRL, 8'h02);
    rchk(`ADDR_IRQ_MASK, 8'h00);
    rchk(8'h20, 8'h00);
    $display("test reset done");
    op(8'h77, 4'h0);
    rchk(`ADDR_STATE, 8'h17);
    op(8'h15, 4'h4);
    rchk(`ADDR_STATE, 8'h15);
    op(8'hd0, 4'h0);
    rchk(`ADDR_STATE, 8'h15);
    op(8'hb0, 4'h0);
    rchk(`ADDR_STATE, 8'h15);
    op(8'h90, 4'h0);
    rchk(`ADDR_STATE, 8'h16);
    op(8'h80, 4'h2);
    rchk(`ADDR_STATE, 8'h15);
    $display("test binary ops done");
    op(8'h1f, 4'h0);
    rchk(`ADDR_STATE, 8'h0f);
    op(8'h90, 4'h0);
    rchk(`ADDR_STATE, 8'h10);
    op(8'h80, 4'h0);
    rchk(`ADDR_STATE, 8'h1f);
    op(8'h00, 4'h0);
    op(8'hc0, 4'h0);
    rchk(`ADDR_STATE, 8'h00);
    $display("test terminal count done");
    wr(`ADDR_CTRL, 8'h03);
    op(8'h19, 4'h0);
    rchk(`ADDR_STATE, 8'h09);
    op(8'h90, 4'h0);
    rchk(`ADDR_STATE, 8'h10);
    op(8'h1b, 4'h0);
    rchk(`ADDR_STATE, 8'h2b);
    op(8'h90, 4'h0);
    rchk(`ADDR_STATE, 8'h10);
    op(8'h1e, 4'h0);
    op(8'h90, 4'h0);
    rchk(`ADDR_STATE, 8'h2f);
    op(8'h90, 4'h0);
    rchk(`ADDR_STATE, 8'h10);
    op(8'h0c, 4'h0);
    op(8'h80, 4'h0);
    rchk(`ADDR_STATE, 8'h19);
    $display("test decimal done");
    // terminal count, load and unused state have all been seen by now
    rchk(`ADDR_IRQ_STATUS, 8'h07);
    wr(`ADDR_IRQ_MASK, 8'h01);
    rchk(`ADDR_IRQ_MASK, 8'h01);
    chk({7'h00, irq}, 8'h01, "irq");
    wr(`ADDR_IRQ_STATUS, 8'h07);
    chk({7'h00, irq}, 8'h00, "irq");
    rchk(`ADDR_IRQ_STATUS, 8'h00);
    $display("test interrupt done");
    wr(`ADDR_STEP, 8'h01);
    rchk(`ADDR_STATE, 8'h18);
    wr(`ADDR_CTRL, 8'h01);
    op(8'h90, 4'h0);
    rchk(`ADDR_STATE, 8'h18);
    $display("test step done");
    final_report;
  end
endmodule // tb_presettable_updown_counter
